//--- ssi_irq_top.sv
`default_nettype none
`include "ssi_regs.svh"
module ssi_irq_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`SSI_ADDR_W-1:0] reg_addr,
  input wire logic [`SSI_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SSI_DATA_W-1:0] reg_rdata,
  input wire logic light_valid,
  input wire logic [`SSI_DATA_W-1:0] light_value,
  input wire logic prox_valid,
  input wire logic [`SSI_DATA_W-1:0] prox_value,
  input wire logic sunlight_enter,
  output logic irq_or_near_far_pin_n_o,
  output logic irq_or_near_far_pin_oe
);

  ssi_pkg::ssi_top_state_t s_r;
  ssi_pkg::ssi_top_state_t s_nxt;
  logic [`SSI_FLAG_W-1:0] set_v;
  logic rd_flags;

  ssi_prox_if prox ();

  // Feed the detector with live samples and the programmed thresholds.
  assign prox.prox_valid = prox_valid;
  assign prox.prox_value = prox_value;
  assign prox.thr_high = s_r.prox_high_threshold;
  assign prox.thr_low = s_r.prox_low_threshold;

  ssi_prox_hyst u_hyst (
    .clk_sys (clk_sys),
    .rst_n (rst_n),
    .p (prox.det)
  );

  // Gathers new events, already gated by their enables.
  always_comb begin
    set_v = `SSI_RST_FLAGS;
    if (s_r.light_irq_enable && light_valid) begin
      set_v[`SSI_FLG_LIGHT_HI] = light_value > s_r.light_high_threshold;
      set_v[`SSI_FLG_LIGHT_LO] = light_value < s_r.light_low_threshold;
    end
    set_v[`SSI_FLG_NEAR] = prox.near_evt
      && s_r.prox_irq_config[`SSI_CONF_CLOSE_EN - `SSI_CONF_CLOSE_EN];
    set_v[`SSI_FLG_FAR] = prox.far_evt
      && s_r.prox_irq_config[`SSI_CONF_AWAY_EN - `SSI_CONF_CLOSE_EN];
    set_v[`SSI_FLG_SUN] = sunlight_enter && (|s_r.prox_irq_config);
  end

  assign rd_flags = reg_rd && (reg_addr == `SSI_OFF_FLAGS);

  // Next state: register writes, read data, flag update and pin level.
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = `SSI_ZERO_DATA;
    // Writes are taken in any cycle, even with the pin pulled low.
    if (reg_wr) begin
      if (reg_addr == `SSI_OFF_CONF) begin
        s_nxt.prox_output_mode_select = reg_wdata[`SSI_CONF_MODE];
        s_nxt.light_irq_enable = reg_wdata[`SSI_CONF_LIGHT_EN];
        s_nxt.prox_irq_config =
          reg_wdata[`SSI_CONF_AWAY_EN:`SSI_CONF_CLOSE_EN];
      end else if (reg_addr == `SSI_OFF_PROX_HI) begin
        s_nxt.prox_high_threshold = reg_wdata;
      end else if (reg_addr == `SSI_OFF_PROX_LO) begin
        s_nxt.prox_low_threshold = reg_wdata;
      end else if (reg_addr == `SSI_OFF_LIGHT_HI) begin
        s_nxt.light_high_threshold = reg_wdata;
      end else if (reg_addr == `SSI_OFF_LIGHT_LO) begin
        s_nxt.light_low_threshold = reg_wdata;
      end
    end
    // Reads answer next cycle; unmapped offsets read zero.
    if (reg_rd) begin
      if (reg_addr == `SSI_OFF_CONF) begin
        s_nxt.rdata[`SSI_CONF_MODE] = s_r.prox_output_mode_select;
        s_nxt.rdata[`SSI_CONF_LIGHT_EN] = s_r.light_irq_enable;
        s_nxt.rdata[`SSI_CONF_AWAY_EN:`SSI_CONF_CLOSE_EN] =
          s_r.prox_irq_config;
      end else if (reg_addr == `SSI_OFF_PROX_HI) begin
        s_nxt.rdata = s_r.prox_high_threshold;
      end else if (reg_addr == `SSI_OFF_PROX_LO) begin
        s_nxt.rdata = s_r.prox_low_threshold;
      end else if (reg_addr == `SSI_OFF_LIGHT_HI) begin
        s_nxt.rdata = s_r.light_high_threshold;
      end else if (reg_addr == `SSI_OFF_LIGHT_LO) begin
        s_nxt.rdata = s_r.light_low_threshold;
      end else if (reg_addr == `SSI_OFF_FLAGS) begin
        s_nxt.rdata[`SSI_FLAG_W-1:0] = s_r.flags;
      end else if (reg_addr == `SSI_OFF_STATE) begin
        s_nxt.rdata[`SSI_ST_NEAR] = prox.near_state;
        s_nxt.rdata[`SSI_ST_PIN] = s_r.pin_oe;
      end
    end
    // A read clears exactly the flags it returned; a set in the same
    // cycle wins so no event is lost between read and clear.
    if (rd_flags) begin
      s_nxt.flags = (s_r.flags & ~s_r.flags) | set_v;
    end else begin
      s_nxt.flags = s_r.flags | set_v;
    end
    // The pin level follows the flags or, in logic output mode, the
    // near/far state; light flags still latch there but stay off the pin.
    if (s_nxt.prox_output_mode_select) begin
      s_nxt.pin_oe = prox.near_state;
    end else begin
      s_nxt.pin_oe = |s_nxt.flags;
    end
    s_nxt.pin_o = 1'b0;
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Open-drain pin: only ever driven low, released otherwise.
  assign irq_or_near_far_pin_n_o = s_r.pin_o;
  assign irq_or_near_far_pin_oe = s_r.pin_oe;
  assign reg_rdata = s_r.rdata;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Checks on the flag path, the pin and the register port.
  a_pin_follows_flags: assert property (
    !s_r.prox_output_mode_select |-> s_r.pin_oe == (|s_r.flags))
    else $error("pin level does not match pending flags");
  a_read_clears_flags: assert property (
    rd_flags && set_v == `SSI_RST_FLAGS
      |=> s_r.flags == `SSI_RST_FLAGS && s_r.rdata[`SSI_FLAG_W-1:0]
        == $past(s_r.flags))
    else $error("flag read did not return and clear the flags");
  a_set_beats_clear: assert property (
    rd_flags && set_v != `SSI_RST_FLAGS
      |=> (s_r.flags & $past(set_v)) == $past(set_v)
        && (s_r.pin_oe || s_r.prox_output_mode_select))
    else $error("event lost during a flag read");
  a_near_mode_pin: assert property (
    s_r.prox_output_mode_select && $past(s_r.prox_output_mode_select)
      |-> s_r.pin_oe == $past(prox.near_state))
    else $error("logic output does not follow near state");
  a_light_gated: assert property (
    !s_r.light_irq_enable && !rd_flags
      |=> ((s_r.flags & ~$past(s_r.flags))
        >> `SSI_FLG_LIGHT_HI) == `SSI_RST_FLAGS)
    else $error("disabled light source raised a flag");
  a_light_high_sets: assert property (
    s_r.light_irq_enable && light_valid
      && light_value > s_r.light_high_threshold
      |=> s_r.flags[`SSI_FLG_LIGHT_HI])
    else $error("light high crossing not flagged");
  a_near_flag_set: assert property (
    prox.near_evt && s_r.prox_irq_config[`SSI_CFG_CLOSE]
      |=> s_r.flags[`SSI_FLG_NEAR]
        && (s_r.pin_oe || s_r.prox_output_mode_select))
    else $error("near event not flagged");
  a_rdata_one_cycle: assert property (
    !reg_rd |=> s_r.rdata == `SSI_ZERO_DATA)
    else $error("read data stood longer than one cycle");
  a_reserved_zero: assert property (
    (s_r.flags & `SSI_FLG_RSVD) == `SSI_RST_FLAGS)
    else $error("reserved flag bit set");

  // Rising flags pull the pin at once; the lag is one edge at most.
  a_pin_on_flag: assert property (
    !s_r.prox_output_mode_select && !reg_wr && set_v != `SSI_RST_FLAGS
      |=> s_r.pin_oe)
    else $error("new flag did not pull the pin low");

  // Flags only leave through a status read or a reset; nothing else may drop one.
  a_flags_hold: assert property (
    !rd_flags |=> (s_r.flags & $past(s_r.flags)) == $past(s_r.flags))
    else $error("flag dropped without a status read");

  // A clean read releases the pin on the very edge that returns the data.
  a_pin_release: assert property (
    !s_r.prox_output_mode_select && rd_flags && set_v == `SSI_RST_FLAGS
      |=> !s_r.pin_oe)
    else $error("pin not released after the status read");

  // The mode bit lands on the edge of its write and reads back as written.
  a_mode_write_lands: assert property (
    reg_wr && reg_addr == `SSI_OFF_CONF
      |=> s_r.prox_output_mode_select == $past(reg_wdata[`SSI_CONF_MODE]))
    else $error("mode bit write did not land");
  a_conf_readback: assert property (
    reg_rd && reg_addr == `SSI_OFF_CONF
      |=> s_r.rdata[`SSI_CONF_MODE] == $past(s_r.prox_output_mode_select))
    else $error("mode bit read back wrong");
  a_state_readback: assert property (
    reg_rd && reg_addr == `SSI_OFF_STATE
      |=> s_r.rdata[`SSI_ST_NEAR] == $past(prox.near_state))
    else $error("near state read back wrong");

  // In logic output mode the pin copies the near state one edge later.
  a_near_pin_low: assert property (
    s_r.prox_output_mode_select && !reg_wr && prox.near_state
      |=> s_r.pin_oe)
    else $error("pin not low while an object is near");
  a_far_pin_high: assert property (
    s_r.prox_output_mode_select && !reg_wr && !prox.near_state
      |=> !s_r.pin_oe)
    else $error("pin not high after the object left");

  // Threshold writes land even while the pin is pulled low.
  a_prox_thr_lands: assert property (
    reg_wr && reg_addr == `SSI_OFF_PROX_HI
      |=> s_r.prox_high_threshold == $past(reg_wdata))
    else $error("proximity high threshold write did not land");
  a_write_while_low: assert property (
    reg_wr && reg_addr == `SSI_OFF_LIGHT_HI && s_r.pin_oe
      |=> s_r.light_high_threshold == $past(reg_wdata))
    else $error("register write lost while the pin was low");

  // Light events in logic output mode must not disturb the pin.
  a_light_off_pin: assert property (
    s_r.prox_output_mode_select && !reg_wr && light_valid
      |=> s_r.pin_oe == $past(prox.near_state))
    else $error("light event reached the pin in logic output mode");

  // Proximity flags come only from sources that the host enabled.
  a_far_flag_set: assert property (
    prox.far_evt && s_r.prox_irq_config[`SSI_CFG_AWAY]
      |=> s_r.flags[`SSI_FLG_FAR])
    else $error("away event not flagged");
  a_near_gated: assert property (
    !s_r.flags[`SSI_FLG_NEAR]
      && !(prox.near_evt && s_r.prox_irq_config[`SSI_CFG_CLOSE])
      |=> !s_r.flags[`SSI_FLG_NEAR])
    else $error("disabled close source raised a flag");
  a_far_gated: assert property (
    !s_r.flags[`SSI_FLG_FAR]
      && !(prox.far_evt && s_r.prox_irq_config[`SSI_CFG_AWAY])
      |=> !s_r.flags[`SSI_FLG_FAR])
    else $error("disabled away source raised a flag");

  // Samples inside the band must never produce a proximity event.
  a_band_quiet: assert property (
    prox_valid && prox_value <= s_r.prox_high_threshold
      && prox_value >= s_r.prox_low_threshold
      |=> !prox.near_evt && !prox.far_evt)
    else $error("proximity event inside the hysteresis band");

  // Sunlight protection lands at its own bit; upper read bits stay zero.
  a_sun_sets: assert property (
    sunlight_enter && (|s_r.prox_irq_config) |=> s_r.flags[`SSI_FLG_SUN])
    else $error("sunlight protection entry not flagged");
  a_sun_gated: assert property (
    !s_r.flags[`SSI_FLG_SUN] && !(sunlight_enter && (|s_r.prox_irq_config))
      |=> !s_r.flags[`SSI_FLG_SUN])
    else $error("sunlight flag set with proximity sources disabled");
  a_flag_rdata_upper: assert property (
    rd_flags |=> s_r.rdata[`SSI_DATA_W-1:`SSI_FLAG_W] == `SSI_RST_FLAGS)
    else $error("status read returned upper bits");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr > `SSI_OFF_STATE |=> s_r.rdata == `SSI_ZERO_DATA)
    else $error("unmapped offset read non-zero");

  // Light below its low threshold is flagged like a high crossing.
  a_light_low_sets: assert property (
    s_r.light_irq_enable && light_valid
      && light_value < s_r.light_low_threshold
      |=> s_r.flags[`SSI_FLG_LIGHT_LO])
    else $error("light low crossing not flagged");

  // A steady near state keeps the logic output level unchanged.
  a_level_holds: assert property (
    s_r.prox_output_mode_select && !reg_wr && $stable(prox.near_state)
      |=> $stable(s_r.pin_oe))
    else $error("logic output level moved without a state change");

  c_flag_read: cover property (
    s_r.pin_oe && rd_flags ##1 !s_r.pin_oe);
  c_near_mode: cover property (
    s_r.prox_output_mode_select && prox.near_evt ##1 s_r.pin_oe);
  c_set_at_read: cover property (rd_flags && set_v != `SSI_RST_FLAGS);
  c_light_low: cover property (##1 s_r.flags[`SSI_FLG_LIGHT_LO]);
  c_far_flag: cover property (
    prox.far_evt && s_r.prox_irq_config[`SSI_CFG_AWAY]);

endmodule
`default_nettype wire

//--- ssi_regs.svh
`ifndef SSI_REGS_SVH
`define SSI_REGS_SVH

// Register bus widths.
`define SSI_ADDR_W 4
`define SSI_DATA_W 16
`define SSI_FLAG_W 8

// Register offsets on the plain register port.
`define SSI_OFF_CONF 4'h0
`define SSI_OFF_PROX_HI 4'h1
`define SSI_OFF_PROX_LO 4'h2
`define SSI_OFF_LIGHT_HI 4'h3
`define SSI_OFF_LIGHT_LO 4'h4
`define SSI_OFF_FLAGS 4'h5
`define SSI_OFF_STATE 4'h6

// Configuration register fields.
`define SSI_CONF_MODE 0
`define SSI_CONF_LIGHT_EN 1
`define SSI_CONF_CLOSE_EN 2
`define SSI_CONF_AWAY_EN 3

// Bits of the two-bit proximity enable field once it sits in the state.
`define SSI_CFG_CLOSE 0
`define SSI_CFG_AWAY 1

// Status flag positions; all other bits are reserved and read zero.
`define SSI_FLG_LIGHT_LO 5
`define SSI_FLG_LIGHT_HI 4
`define SSI_FLG_SUN 2
`define SSI_FLG_NEAR 1
`define SSI_FLG_FAR 0
`define SSI_FLG_RSVD 8'hC8

// Live state register fields.
`define SSI_ST_NEAR 0
`define SSI_ST_PIN 1

// Reset values.
`define SSI_RST_THR 16'h0000
`define SSI_RST_FLAGS 8'h00
`define SSI_ZERO_DATA 16'h0000

`endif

//--- ssi_pkg.sv
`default_nettype none
`include "ssi_regs.svh"
package ssi_pkg;

  // Whole state of the top module.
  typedef struct packed {
    logic prox_output_mode_select;
    logic light_irq_enable;
    logic [1:0] prox_irq_config;
    logic [`SSI_DATA_W-1:0] prox_high_threshold;
    logic [`SSI_DATA_W-1:0] prox_low_threshold;
    logic [`SSI_DATA_W-1:0] light_high_threshold;
    logic [`SSI_DATA_W-1:0] light_low_threshold;
    logic [`SSI_FLAG_W-1:0] flags;
    logic [`SSI_DATA_W-1:0] rdata;
    logic pin_oe;
    logic pin_o;
  } ssi_top_state_t;

  // Whole state of the near/far detector.
  typedef struct packed {
    logic near;
    logic near_evt;
    logic far_evt;
  } ssi_hyst_state_t;

endpackage
`default_nettype wire

//--- ssi_prox_if.sv
`default_nettype none
`include "ssi_regs.svh"
// Proximity samples and thresholds in, near/far state and events out.
interface ssi_prox_if;
  logic prox_valid;
  logic [`SSI_DATA_W-1:0] prox_value;
  logic [`SSI_DATA_W-1:0] thr_high;
  logic [`SSI_DATA_W-1:0] thr_low;
  logic near_state;
  logic near_evt;
  logic far_evt;

  modport ctl (
    output prox_valid, prox_value, thr_high, thr_low,
    input near_state, near_evt, far_evt
  );
  modport det (
    input prox_valid, prox_value, thr_high, thr_low,
    output near_state, near_evt, far_evt
  );
endinterface
`default_nettype wire

//--- ssi_prox_hyst.sv
`default_nettype none
`include "ssi_regs.svh"
// Near/far decision with hysteresis between the two thresholds.
module ssi_prox_hyst (
  input wire logic clk_sys,
  input wire logic rst_n,
  ssi_prox_if.det p
);

  ssi_pkg::ssi_hyst_state_t s_r;
  ssi_pkg::ssi_hyst_state_t s_nxt;
  logic above;
  logic below;

  // Events fire only on a change of state, so values that stay between the
  // thresholds can never re-trigger.
  always_comb begin
    above = p.prox_value > p.thr_high;
    below = p.prox_value < p.thr_low;
    s_nxt = s_r;
    s_nxt.near_evt = 1'b0;
    s_nxt.far_evt = 1'b0;
    if (p.prox_valid && above && !s_r.near) begin
      s_nxt.near = 1'b1;
      s_nxt.near_evt = 1'b1;
    end else if (p.prox_valid && below && s_r.near) begin
      s_nxt.near = 1'b0;
      s_nxt.far_evt = 1'b1;
    end
  end

  // State register; the detector starts in the far state.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign p.near_state = s_r.near;
  assign p.near_evt = s_r.near_evt;
  assign p.far_evt = s_r.far_evt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_near_on_cross: assert property (
    p.prox_valid && above && !s_r.near |=> s_r.near && s_r.near_evt)
    else $error("near not entered on crossing the high threshold");
  a_far_on_drop: assert property (
    p.prox_valid && below && s_r.near |=> !s_r.near && s_r.far_evt)
    else $error("far not entered on dropping below the low threshold");
  a_hold_between: assert property (
    p.prox_valid && !above && !below
      |=> $stable(s_r.near) && !s_r.near_evt && !s_r.far_evt)
    else $error("state changed inside the hysteresis band");

endmodule
`default_nettype wire

//--- ssi_host_model.sv
`default_nettype none
`include "ssi_regs.svh"
// Host side of the block: owns the register port and watches the pin.
module ssi_host_model (
  input wire logic clk_sys,
  output logic [`SSI_ADDR_W-1:0] reg_addr,
  output logic [`SSI_DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [`SSI_DATA_W-1:0] reg_rdata,
  input wire logic pin_n_o,
  input wire logic pin_oe,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 100ps;

  // The line has a pull-up, so a released pin reads high and never stale.
  assign pin_level = pin_oe ? pin_n_o : 1'b1;

  // Bus idle at time zero.
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines get inverted values so stale data cannot pass.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- ssi_irq_top_tb.sv
`default_nettype none
`include "ssi_regs.svh"
module ssi_irq_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [3:0] conf;
    logic [1:0] src;
    logic [15:0] val;
    logic [7:0] flg;
  } ssi_row_t;

  // Thresholds: prox 100/50, light 1000/200; src 0 light, 1 prox, 2 sun.
  localparam ssi_row_t ROWS [10] = '{
    '{4'h2, 2'h0, 16'h05DC, 8'h10}, '{4'h2, 2'h0, 16'h0064, 8'h20},
    '{4'h2, 2'h0, 16'h01F4, 8'h00}, '{4'h0, 2'h0, 16'h05DC, 8'h00},
    '{4'h4, 2'h1, 16'h0096, 8'h02}, '{4'h4, 2'h1, 16'h0046, 8'h00},
    '{4'hC, 2'h1, 16'h0014, 8'h01}, '{4'h4, 2'h2, 16'h0000, 8'h04},
    '{4'h8, 2'h1, 16'h0096, 8'h00}, '{4'h8, 2'h1, 16'h001E, 8'h01}};

  logic clk_sys, rst_n, reg_wr, reg_rd, light_valid, prox_valid;
  logic sunlight_enter, pin_n_o, pin_oe, pin_level;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, light_value, prox_value, d;
  int failures, checks_done;

  ssi_irq_top ssi_irq_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .light_valid(light_valid),
    .light_value(light_value), .prox_valid(prox_valid),
    .prox_value(prox_value), .sunlight_enter(sunlight_enter),
    .irq_or_near_far_pin_n_o(pin_n_o), .irq_or_near_far_pin_oe(pin_oe));

  ssi_host_model ssi_host_model_inst (.clk_sys(clk_sys),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_n_o(pin_n_o),
    .pin_oe(pin_oe), .pin_level(pin_level));

  // Clock of 4 ns.
  always #2 clk_sys = ~clk_sys;

  task automatic wrap_up();
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t pin %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] v;
    ssi_host_model_inst.rd(a, v);
    chk16(v, e);
  endtask

  // Three idle edges cover the two-cycle proximity path plus the pin lag.
  task automatic samp(input logic [1:0] s, input logic [15:0] v);
    @(posedge clk_sys);
    light_valid <= (s == 2'h0);
    prox_valid <= (s == 2'h1);
    sunlight_enter <= (s == 2'h2);
    light_value <= v;
    prox_value <= v;
    @(posedge clk_sys);
    light_valid <= 1'b0;
    prox_valid <= 1'b0;
    sunlight_enter <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // A hang ends the run as a failure.
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    light_valid = 1'b0;
    prox_valid = 1'b0;
    sunlight_enter = 1'b0;
    light_value = 16'h0000;
    prox_value = 16'h0000;
    failures = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk1(pin_oe, 1'b0);
    rdchk(`SSI_OFF_FLAGS, 16'h0000);
    rdchk(`SSI_OFF_STATE, 16'h0000);
    ssi_host_model_inst.wr(`SSI_OFF_PROX_HI, 16'h0064);
    ssi_host_model_inst.wr(`SSI_OFF_PROX_LO, 16'h0032);
    ssi_host_model_inst.wr(`SSI_OFF_LIGHT_HI, 16'h03E8);
    ssi_host_model_inst.wr(`SSI_OFF_LIGHT_LO, 16'h00C8);
    rdchk(`SSI_OFF_PROX_LO, 16'h0032);
    rdchk(`SSI_OFF_LIGHT_HI, 16'h03E8);
    // Ordinary events, one row each, read back and cleared.
    foreach (ROWS[i]) begin
      ssi_host_model_inst.wr(`SSI_OFF_CONF, {12'h000, ROWS[i].conf});
      samp(ROWS[i].src, ROWS[i].val);
      chk1(pin_level, ROWS[i].flg == 8'h00);
      rdchk(`SSI_OFF_FLAGS, {8'h00, ROWS[i].flg});
      chk1(pin_level, 1'b1);
      rdchk(`SSI_OFF_FLAGS, 16'h0000);
    end
    rdchk(4'hF, 16'h0000);
    ssi_host_model_inst.wr(`SSI_OFF_STATE, 16'hFFFF);
    rdchk(`SSI_OFF_STATE, 16'h0000);
    // A flag set in the read's own cycle must survive the clear.
    ssi_host_model_inst.wr(`SSI_OFF_CONF, 16'h0002);
    samp(2'h0, 16'h05DC);
    fork
      ssi_host_model_inst.rd(`SSI_OFF_FLAGS, d);
      begin
        @(posedge clk_sys);
        light_valid <= 1'b1;
        light_value <= 16'h0064;
        @(posedge clk_sys);
        light_valid <= 1'b0;
      end
    join
    chk16(d, 16'h0010);
    chk1(pin_level, 1'b0);
    rdchk(`SSI_OFF_FLAGS, 16'h0020);
    // Near/far output mode with light interrupts still enabled.
    ssi_host_model_inst.wr(`SSI_OFF_CONF, 16'h0003);
    rdchk(`SSI_OFF_CONF, 16'h0003);
    samp(2'h0, 16'h05DC);
    chk1(pin_level, 1'b1);
    samp(2'h1, 16'h0096);
    chk1(pin_level, 1'b0);
    rdchk(`SSI_OFF_STATE, 16'h0003);
    samp(2'h1, 16'h0046);
    chk1(pin_level, 1'b0);
    rdchk(`SSI_OFF_FLAGS, 16'h0010);
    chk1(pin_level, 1'b0);
    samp(2'h1, 16'h0014);
    chk1(pin_level, 1'b1);
    samp(2'h1, 16'h0046);
    chk1(pin_level, 1'b1);
    // A reset in mid-run drops flags, near state and settings.
    samp(2'h1, 16'h0096);
    samp(2'h0, 16'h05DC);
    chk1(pin_level, 1'b0);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk1(pin_level, 1'b1);
    rdchk(`SSI_OFF_FLAGS, 16'h0000);
    rdchk(`SSI_OFF_STATE, 16'h0000);
    rdchk(`SSI_OFF_CONF, 16'h0000);
    rdchk(`SSI_OFF_PROX_HI, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
